// ==== common/biquad_bank_defs.svh ====
// Constants for the servo anti-resonance biquad bank.
`ifndef BIQUAD_BANK_DEFS_SVH
`define BIQUAD_BANK_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define SAMPLE_PERIOD_NS 62500
`define SAMPLE_TICKS (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

// ****************************************************************
// Number formats
// ****************************************************************
`define DATA_W 16
`define COEF_W 18
`define GAIN_W 24
`define FRAC 14
`define KAFF_FRAC 8
`define COEF_ONE 18'sh04000
`define Q_HALF 16'h0080

// ****************************************************************
// Register map and reset values
// ****************************************************************
`define REG_TYPE 4'h0
`define REG_ZERO_FREQ 4'h1
`define REG_ZERO_Q 4'h2
`define REG_POLE_FREQ 4'h3
`define REG_POLE_Q 4'h4
`define REG_ZERO_EXP 4'h5
`define REG_ZERO_COS 4'h6
`define REG_ZERO_COSH 4'h7
`define REG_POLE_EXP 4'h8
`define REG_POLE_COS 4'h9
`define REG_POLE_COSH 4'hA
`define REG_KAFF 7'h40
`define REG_CONTROL 7'h41
`define REG_STATUS 7'h42
`define REG_CMD_OUT 7'h43
`define REG_FB_OUT 7'h44
`define CTRL_APPLY_BIT 0
`define TYPE_RESET 3'h4
`define Q_RESET 16'h00B5
`define FREQ_RESET 16'h0000
`define COEF_RESET 18'sh00000
`define KAFF_RESET 16'h0000

`endif

// ==== common/biquad_bank_pkg.sv ====
// Types and shared arithmetic for the biquad bank.
`include "biquad_bank_defs.svh"
`default_nettype none

package biquad_bank_pkg;

    typedef enum logic [2:0] {
        FT_BIQUAD = 3'h0,
        FT_LOW_PASS = 3'h1,
        FT_LEAD_LAG = 3'h2,
        FT_NOTCH = 3'h3,
        FT_UNITY = 3'h4
    } filter_type_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LOAD = 5'h02,
        ST_DIV = 5'h04,
        ST_NEXT = 5'h08,
        ST_COMMIT = 5'h10
    } calc_state_e;

    typedef logic signed [`COEF_W-1:0] coef_t;
    typedef logic signed [`DATA_W-1:0] sample_t;

    // Clamps a wide signed value to the sample range.
    function automatic sample_t saturate(input logic signed [63:0] v);
        if (v > 64'sh0000_0000_0000_7FFF) begin
            saturate = 16'sh7FFF;
        end else if (v < -64'sh0000_0000_0000_8000) begin
            saturate = 16'sh8000;
        end else begin
            saturate = v[15:0];
        end
    endfunction : saturate

endpackage : biquad_bank_pkg

`default_nettype wire

// ==== core/biquad_stage.sv ====
// One direct-form second-order section with unity bypass.
`include "biquad_bank_defs.svh"
`default_nettype none

module biquad_stage (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic bypass,
    input wire logic signed [`GAIN_W-1:0] gain,
    input wire logic signed [`COEF_W-1:0] n1,
    input wire logic signed [`COEF_W-1:0] n0,
    input wire logic signed [`COEF_W-1:0] d1,
    input wire logic signed [`COEF_W-1:0] d0,
    input wire logic signed [`DATA_W-1:0] x,
    output logic signed [`DATA_W-1:0] y
);

    logic signed [`DATA_W-1:0] x1_q;
    logic signed [`DATA_W-1:0] x2_q;
    logic signed [`DATA_W-1:0] y2_q;

    // The leading numerator coefficient is one, so it costs no multiplier.
    wire signed [37:0] numAcc = (38'(x) <<< `FRAC) + 38'(n1 * x1_q)
                              + 38'(n0 * x2_q);
    wire signed [61:0] scaled = 62'(gain * numAcc) >>> `FRAC;
    wire signed [61:0] fbAcc = 62'(d1 * y) + 62'(d0 * y2_q);
    wire signed [61:0] yFull = (scaled - fbAcc) >>> `FRAC;
    wire signed [`DATA_W-1:0] ySat = biquad_bank_pkg::saturate(64'(yFull));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            x1_q <= 16'sh0000;
            x2_q <= 16'sh0000;
            y <= 16'sh0000;
            y2_q <= 16'sh0000;
        end else if (tick) begin
            x1_q <= x;
            x2_q <= x1_q;
            y2_q <= y;
            y <= bypass ? x : ySat;
        end
    end

endmodule : biquad_stage

`default_nettype wire

// ==== core/coef_divider.sv ====
// Serial signed divider giving the numerator gain in Q14.
`include "biquad_bank_defs.svh"
`default_nettype none

module coef_divider (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic signed [19:0] dividend,
    input wire logic signed [19:0] divisor,
    output logic done,
    output logic signed [`GAIN_W-1:0] quotient
);

    logic [33:0] num_q;
    logic [33:0] quo_q;
    logic [20:0] rem_q;
    logic [19:0] den_q;
    logic [5:0] count_q;
    logic busy_q;
    logic neg_q;

    wire [19:0] dividendMag = dividend[19] ? 20'(-dividend) : dividend;
    wire [19:0] divisorMag = divisor[19] ? 20'(-divisor) : divisor;
    wire [20:0] trial = {rem_q[19:0], num_q[33]};
    wire fits = trial >= {1'b0, den_q};
    wire [33:0] nextQuo = {quo_q[32:0], fits};
    // A zero divisor yields all ones, which clamps to full scale.
    wire tooBig = |nextQuo[33:23];
    wire [22:0] magOut = tooBig ? 23'h7FFFFF : nextQuo[22:0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            num_q <= 34'h0;
            quo_q <= 34'h0;
            rem_q <= 21'h0;
            den_q <= 20'h0;
            count_q <= 6'h0;
            busy_q <= 1'b0;
            neg_q <= 1'b0;
            done <= 1'b0;
            quotient <= 24'sh000000;
        end else begin
            done <= 1'b0;
            if (start && !busy_q) begin
                num_q <= {dividendMag, 14'h0};
                den_q <= divisorMag;
                neg_q <= dividend[19] ^ divisor[19];
                rem_q <= 21'h0;
                quo_q <= 34'h0;
                count_q <= 6'h22;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= fits ? 21'(trial - {1'b0, den_q}) : trial;
                num_q <= {num_q[32:0], 1'b0};
                quo_q <= nextQuo;
                count_q <= 6'(count_q - 6'h01);
                if (count_q == 6'h01) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                    quotient <= neg_q ? -$signed({1'b0, magOut})
                                      : $signed({1'b0, magOut});
                end
            end
        end
    end

endmodule : coef_divider

`default_nettype wire

// ==== core/servo_antiresonance_biquad_bank.sv ====
// Four-stage anti-resonance biquad bank with acceleration feedforward.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "biquad_bank_defs.svh"
`default_nettype none

// How it works
// - Four stages, two forward, two feedback.
// - Forward pair filters the PI output in series.
// - Unity type passes the input unchanged.
// - Forward shapes command; feedback shapes measurement only.
// - Every shape uses one general biquad datapath.
// - Zero and pole Q configure stages; frequency is only stored.
// - Prototype has zero numerator over pole denominator.
// - Matched pole/zero mapping at 62.5 us sampling.
// - Q above one half selects cosine, else cosh.
// - Numerator: 1, -2 E C, and E.
// - Denominator built alike, leading term fixed one.
// - Numerator rescaled for unity gain at DC.
// - Type zero selects the general biquad form.
// - Low pass via higher zero, lower pole.
// - Lead-lag: flat low end, set high gain.
// - Notch by frequency, depth and Q.
// - Zero below pole gives high-frequency gain.
// - Scaled acceleration feedforward adds to current command.
module servo_antiresonance_biquad_bank #(
    parameter int SAMPLE_CYCLES = `SAMPLE_TICKS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    input wire logic signed [15:0] piOutput,
    input wire logic signed [15:0] velocityFeedback,
    input wire logic signed [15:0] accelCommand,
    output logic signed [15:0] currentCommand,
    output logic signed [15:0] feedbackFiltered,
    output logic sampleTick
);

    // ****************************************************************
    // Software-visible settings
    // ****************************************************************
    biquad_bank_pkg::filter_type_e stageFilterType_q [4];
    logic [15:0] zeroFrequency_q [4];
    logic [15:0] zeroQuality_q [4];
    logic [15:0] poleFrequency_q [4];
    logic [15:0] poleQuality_q [4];
    biquad_bank_pkg::coef_t zeroExp_q [4];
    biquad_bank_pkg::coef_t zeroCos_q [4];
    biquad_bank_pkg::coef_t zeroCosh_q [4];
    biquad_bank_pkg::coef_t poleExp_q [4];
    biquad_bank_pkg::coef_t poleCos_q [4];
    biquad_bank_pkg::coef_t poleCosh_q [4];
    logic signed [15:0] accelFeedforwardGain_q;

    // ****************************************************************
    // Coefficient sets: pending while computed, active in use
    // ****************************************************************
    logic signed [`GAIN_W-1:0] penGain_q [4];
    biquad_bank_pkg::coef_t penN1_q [4];
    biquad_bank_pkg::coef_t penN0_q [4];
    biquad_bank_pkg::coef_t penD1_q [4];
    biquad_bank_pkg::coef_t penD0_q [4];
    logic signed [`GAIN_W-1:0] actGain_q [4];
    biquad_bank_pkg::coef_t actN1_q [4];
    biquad_bank_pkg::coef_t actN0_q [4];
    biquad_bank_pkg::coef_t actD1_q [4];
    biquad_bank_pkg::coef_t actD0_q [4];
    logic [3:0] actBypass_q;

    biquad_bank_pkg::calc_state_e state_q;
    logic [1:0] calcIdx_q;
    logic [7:0] commitCount_q;
    logic divStart_q;
    logic [12:0] tickCount_q;
    logic signed [15:0] stageOut [4];
    logic [31:0] readMux;

    // First-order term of the matched mapping: -2 * E * C.
    function automatic biquad_bank_pkg::coef_t firstOrder(
        input biquad_bank_pkg::coef_t e,
        input biquad_bank_pkg::coef_t c
    );
        logic signed [35:0] prod;
        prod = e * c;
        firstOrder = 18'(-(prod >>> (`FRAC - 1)));
    endfunction : firstOrder

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire stageSpace = ~regAddr[6];
    wire [1:0] stageSel = regAddr[5:4];
    wire [3:0] field = regAddr[3:0];
    wire stageWrite = regWrite && stageSpace;
    wire applyReq = regWrite && (regAddr == `REG_CONTROL)
                    && regWriteData[`CTRL_APPLY_BIT];
    wire busy = (state_q != biquad_bank_pkg::ST_IDLE);

    // ****************************************************************
    // Coefficient calculation for the stage under work
    // ****************************************************************
    wire [1:0] ci = calcIdx_q;
    wire zeroRadPos = zeroQuality_q[ci] > `Q_HALF;
    wire poleRadPos = poleQuality_q[ci] > `Q_HALF;
    wire biquad_bank_pkg::coef_t zeroTrig =
        zeroRadPos ? zeroCos_q[ci] : zeroCosh_q[ci];
    wire biquad_bank_pkg::coef_t poleTrig =
        poleRadPos ? poleCos_q[ci] : poleCosh_q[ci];
    wire biquad_bank_pkg::coef_t nu1 = firstOrder(zeroExp_q[ci], zeroTrig);
    wire biquad_bank_pkg::coef_t nu0 = zeroExp_q[ci];
    wire biquad_bank_pkg::coef_t de1 = firstOrder(poleExp_q[ci], poleTrig);
    wire biquad_bank_pkg::coef_t de0 = poleExp_q[ci];
    // Zeros on top, poles below, each with a unit leading term.
    wire signed [19:0] sumNu = 20'(`COEF_ONE) + 20'(nu1) + 20'(nu0);
    wire signed [19:0] sumDe = 20'(`COEF_ONE) + 20'(de1) + 20'(de0);
    wire divDone;
    wire signed [`GAIN_W-1:0] divQuot;

    // Gain = sum(den) / sum(num), so the numerator is divided by its scale.
    coef_divider scaleDivider (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(divStart_q),
        .dividend(sumDe),
        .divisor(sumNu),
        .done(divDone),
        .quotient(divQuot)
    );

    // ****************************************************************
    // Settings registers
    // ****************************************************************
    // Settings may change while a calculation runs; the result then mixes
    // old and new values, so software should wait for busy to clear.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                stageFilterType_q[i] <= biquad_bank_pkg::FT_UNITY;
                zeroFrequency_q[i] <= `FREQ_RESET;
                zeroQuality_q[i] <= `Q_RESET;
                poleFrequency_q[i] <= `FREQ_RESET;
                poleQuality_q[i] <= `Q_RESET;
                zeroExp_q[i] <= `COEF_RESET;
                zeroCos_q[i] <= `COEF_RESET;
                zeroCosh_q[i] <= `COEF_RESET;
                poleExp_q[i] <= `COEF_RESET;
                poleCos_q[i] <= `COEF_RESET;
                poleCosh_q[i] <= `COEF_RESET;
            end
        end else if (stageWrite) begin
            case (field)
                `REG_TYPE: stageFilterType_q[stageSel] <=
                    biquad_bank_pkg::filter_type_e'(regWriteData[2:0]);
                `REG_ZERO_FREQ: zeroFrequency_q[stageSel] <= regWriteData[15:0];
                `REG_ZERO_Q: zeroQuality_q[stageSel] <= regWriteData[15:0];
                `REG_POLE_FREQ: poleFrequency_q[stageSel] <= regWriteData[15:0];
                `REG_POLE_Q: poleQuality_q[stageSel] <= regWriteData[15:0];
                `REG_ZERO_EXP: zeroExp_q[stageSel] <= regWriteData[17:0];
                `REG_ZERO_COS: zeroCos_q[stageSel] <= regWriteData[17:0];
                `REG_ZERO_COSH: zeroCosh_q[stageSel] <= regWriteData[17:0];
                `REG_POLE_EXP: poleExp_q[stageSel] <= regWriteData[17:0];
                `REG_POLE_COS: poleCos_q[stageSel] <= regWriteData[17:0];
                `REG_POLE_COSH: poleCosh_q[stageSel] <= regWriteData[17:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            accelFeedforwardGain_q <= `KAFF_RESET;
        end else if (regWrite && regAddr == `REG_KAFF) begin
            accelFeedforwardGain_q <= regWriteData[15:0];
        end
    end

    // ****************************************************************
    // Calculation sequencer
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= biquad_bank_pkg::ST_IDLE;
            calcIdx_q <= 2'h0;
            divStart_q <= 1'b0;
            commitCount_q <= 8'h00;
        end else begin
            divStart_q <= 1'b0;
            case (state_q)
                biquad_bank_pkg::ST_IDLE: begin
                    if (applyReq) begin
                        calcIdx_q <= 2'h0;
                        state_q <= biquad_bank_pkg::ST_LOAD;
                    end
                end
                biquad_bank_pkg::ST_LOAD: begin
                    divStart_q <= 1'b1;
                    state_q <= biquad_bank_pkg::ST_DIV;
                end
                biquad_bank_pkg::ST_DIV: begin
                    if (divDone) begin
                        state_q <= biquad_bank_pkg::ST_NEXT;
                    end
                end
                biquad_bank_pkg::ST_NEXT: begin
                    if (calcIdx_q == 2'h3) begin
                        state_q <= biquad_bank_pkg::ST_COMMIT;
                    end else begin
                        calcIdx_q <= 2'(calcIdx_q + 2'h1);
                        state_q <= biquad_bank_pkg::ST_LOAD;
                    end
                end
                biquad_bank_pkg::ST_COMMIT: begin
                    commitCount_q <= 8'(commitCount_q + 8'h01);
                    state_q <= biquad_bank_pkg::ST_IDLE;
                end
                default: state_q <= biquad_bank_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                penGain_q[i] <= 24'sh004000;
                penN1_q[i] <= `COEF_RESET;
                penN0_q[i] <= `COEF_RESET;
                penD1_q[i] <= `COEF_RESET;
                penD0_q[i] <= `COEF_RESET;
            end
        end else if (state_q == biquad_bank_pkg::ST_DIV && divDone) begin
            penGain_q[ci] <= divQuot;
            penN1_q[ci] <= nu1;
            penN0_q[ci] <= nu0;
            penD1_q[ci] <= de1;
            penD0_q[ci] <= de0;
        end
    end

    // All four stages switch in one cycle, so no sample mixes sets.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            actBypass_q <= 4'hF;
            for (int i = 0; i < 4; i++) begin
                actGain_q[i] <= 24'sh004000;
                actN1_q[i] <= `COEF_RESET;
                actN0_q[i] <= `COEF_RESET;
                actD1_q[i] <= `COEF_RESET;
                actD0_q[i] <= `COEF_RESET;
            end
        end else if (state_q == biquad_bank_pkg::ST_COMMIT) begin
            for (int i = 0; i < 4; i++) begin
                actBypass_q[i] <=
                    stageFilterType_q[i] == biquad_bank_pkg::FT_UNITY;
                actGain_q[i] <= penGain_q[i];
                actN1_q[i] <= penN1_q[i];
                actN0_q[i] <= penN0_q[i];
                actD1_q[i] <= penD1_q[i];
                actD0_q[i] <= penD0_q[i];
            end
        end
    end

    // ****************************************************************
    // Sample timing and filter chains
    // ****************************************************************
    wire tickNow = tickCount_q == 13'(SAMPLE_CYCLES - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tickCount_q <= 13'h0000;
            sampleTick <= 1'b0;
        end else begin
            tickCount_q <= tickNow ? 13'h0000 : 13'(tickCount_q + 13'h0001);
            sampleTick <= tickNow;
        end
    end

    // Stages 0 and 1 carry the command, 2 and 3 the measured feedback.
    wire signed [15:0] stageIn [4];
    assign stageIn[0] = piOutput;
    assign stageIn[1] = stageOut[0];
    assign stageIn[2] = velocityFeedback;
    assign stageIn[3] = stageOut[2];

    // Every filter shape runs through the same section; only coefficients
    // differ, so low pass, lead-lag and notch need no datapath of their own.
    for (genvar s = 0; s < 4; s++) begin : gStage
        biquad_stage section (
            .ref_clk(ref_clk),
            .rst(rst),
            .tick(sampleTick),
            .bypass(actBypass_q[s]),
            .gain(actGain_q[s]),
            .n1(actN1_q[s]),
            .n0(actN0_q[s]),
            .d1(actD1_q[s]),
            .d0(actD0_q[s]),
            .x(stageIn[s]),
            .y(stageOut[s])
        );
    end

    wire signed [31:0] ffProd = accelFeedforwardGain_q * accelCommand;
    wire signed [63:0] ffSum = 64'(stageOut[1])
                             + 64'(ffProd >>> `KAFF_FRAC);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            currentCommand <= 16'sh0000;
            feedbackFiltered <= 16'sh0000;
        end else if (sampleTick) begin
            currentCommand <= biquad_bank_pkg::saturate(ffSum);
            feedbackFiltered <= stageOut[3];
        end
    end

    // ****************************************************************
    // Read-back
    // ****************************************************************
    always_comb begin
        readMux = 32'h0000_0000;
        if (stageSpace) begin
            case (field)
                `REG_TYPE: readMux = 32'(stageFilterType_q[stageSel]);
                `REG_ZERO_FREQ: readMux = 32'(zeroFrequency_q[stageSel]);
                `REG_ZERO_Q: readMux = 32'(zeroQuality_q[stageSel]);
                `REG_POLE_FREQ: readMux = 32'(poleFrequency_q[stageSel]);
                `REG_POLE_Q: readMux = 32'(poleQuality_q[stageSel]);
                `REG_ZERO_EXP: readMux = 32'({14'h0, zeroExp_q[stageSel]});
                `REG_ZERO_COS: readMux = 32'({14'h0, zeroCos_q[stageSel]});
                `REG_ZERO_COSH: readMux = 32'({14'h0, zeroCosh_q[stageSel]});
                `REG_POLE_EXP: readMux = 32'({14'h0, poleExp_q[stageSel]});
                `REG_POLE_COS: readMux = 32'({14'h0, poleCos_q[stageSel]});
                `REG_POLE_COSH: readMux = 32'({14'h0, poleCosh_q[stageSel]});
                default: readMux = 32'h0000_0000;
            endcase
        end else begin
            case (regAddr)
                `REG_KAFF: readMux = {16'h0000, accelFeedforwardGain_q};
                `REG_STATUS: readMux = {23'h0, commitCount_q, busy};
                `REG_CMD_OUT: readMux = {16'h0000, currentCommand};
                `REG_FB_OUT: readMux = {16'h0000, feedbackFiltered};
                default: readMux = 32'h0000_0000;
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regReadData <= 32'h0000_0000;
        end else begin
            regReadData <= regRead ? readMux : 32'h0000_0000;
        end
    end

endmodule : servo_antiresonance_biquad_bank

`default_nettype wire

// ==== verification/biquad_bank_props.sv ====
// Port checker for the biquad bank, bound to its top module.
`default_nettype none
module biquad_bank_props #(
    parameter int SAMPLE_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regReadData,
    input wire logic signed [15:0] currentCommand,
    input wire logic signed [15:0] feedbackFiltered,
    input wire logic sampleTick
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // Pacing and read-back checks
    // ********
    // Gaps are judged from the first tick on, so the reset phase is free.
    int gap_q;
    logic seen_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= sampleTick ? 1 : gap_q + 1;
            seen_q <= seen_q | sampleTick;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence readOf(logic [6:0] a);
        regRead && regAddr == a;
    endsequence
    a_tick_exact: assert property (
        sampleTick && seen_q |-> gap_q == SAMPLE_CYCLES) else $error("bad gap");
    a_tick_gap: assert property (seen_q |-> gap_q <= SAMPLE_CYCLES)
        else $error("tick missing");
    a_tick_pulse: assert property (sampleTick |=> !sampleTick)
        else $error("tick too long");
    a_cmd_hold: assert property (!sampleTick |=> $stable(currentCommand))
        else $error("command moved between ticks");
    a_fb_hold: assert property (!sampleTick |=> $stable(feedbackFiltered))
        else $error("feedback moved between ticks");
    a_read_idle: assert property (!$past(regRead) |-> regReadData == 32'h0)
        else $error("read data outside its cycle");
    a_read_unmapped: assert property (readOf(7'h7F) |=> regReadData == 32'h0)
        else $error("unmapped read not zero");
    a_type_width: assert property (
        regRead && regAddr < 7'h40 && regAddr[3:0] == 4'h0
        |=> regReadData[31:3] == 29'h0) else $error("type read too wide");
endmodule : biquad_bank_props
bind servo_antiresonance_biquad_bank biquad_bank_props #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
) props_i (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regRead(regRead), .regReadData(regReadData),
    .currentCommand(currentCommand), .feedbackFiltered(feedbackFiltered),
    .sampleTick(sampleTick));
`default_nettype wire

// ==== verification/servo_partner.sv ====
// Upstream controller and feedback source model for the bank.
`default_nettype none
module servo_partner (
    input wire logic ref_clk,
    input wire logic sampleTick,
    input wire logic signed [15:0] piSet,
    input wire logic signed [15:0] fbSet,
    input wire logic signed [15:0] accSet,
    output logic signed [15:0] piOutput = 16'h0000,
    output logic signed [15:0] velocityFeedback = 16'h0000,
    output logic signed [15:0] accelCommand = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // New values appear only on a tick, as from a sampled controller.
    always @(posedge ref_clk) begin
        if (sampleTick) begin
            piOutput <= piSet;
            velocityFeedback <= fbSet;
            accelCommand <= accSet;
        end
    end
endmodule : servo_partner
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the biquad bank.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] regAddr = 7'h00;
    logic [31:0] regWriteData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regReadData;
    logic [31:0] rdVal;
    logic signed [15:0] piOutput, velocityFeedback, accelCommand, mx;
    logic signed [15:0] currentCommand, feedbackFiltered;
    logic signed [15:0] piSet = 16'h03E8, fbSet = 16'hFE0C, accSet = 16'h0;
    logic sampleTick;
    int fails = 0;
    int comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    servo_antiresonance_biquad_bank #(.SAMPLE_CYCLES(20))
        servo_antiresonance_biquad_bank_i (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData), .piOutput(piOutput),
        .velocityFeedback(velocityFeedback), .accelCommand(accelCommand),
        .currentCommand(currentCommand), .feedbackFiltered(feedbackFiltered),
        .sampleTick(sampleTick));
    servo_partner servo_partner_i (.ref_clk(ref_clk), .sampleTick(sampleTick),
        .piSet(piSet), .fbSet(fbSet), .accSet(accSet), .piOutput(piOutput),
        .velocityFeedback(velocityFeedback), .accelCommand(accelCommand));
    // ********
    // Bus tasks and verdict
    // ********
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [6:0] a, logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    // An empty name only fetches the word, for polling.
    task automatic rd(logic [6:0] a, logic [31:0] exp, string what);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rdVal = regReadData;
        if (what != "") chk(what, exp, rdVal);
    endtask : rd
    task automatic tk(int n);
        repeat (n) @(negedge sampleTick);
        #1;
    endtask : tk
    task automatic stop_test;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        #200us;
        fails++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            rd(7'(16 * s), 32'h4, "type reset");
            rd(7'(16 * s + 2), 32'hB5, "zero q reset");
        end
        rd(7'h7F, 32'h0, "unmapped");
        tk(4);
        rd(7'h43, 32'h3E8, "command unity");
        rd(7'h44, 32'hFE0C, "feedback unity");
        wr(7'h40, 32'h200);
        accSet <= 16'h0064;
        tk(3);
        rd(7'h40, 32'h200, "ff gain");
        rd(7'h43, 32'h4B0, "feedforward");
        rd(7'h44, 32'hFE0C, "feedback no ff");
        accSet <= 16'h0;
        wr(7'h00, 32'h0);
        wr(7'h08, 32'h2000);
        wr(7'h41, 32'h1);
        rd(7'h42, 32'h1, "busy");
        wr(7'h41, 32'h1);
        for (int i = 0; i < 400 && rdVal[0] !== 1'b0; i++) rd(7'h42, 0, "");
        rd(7'h42, 32'h2, "one commit");
        tk(4);
        piSet <= 16'h07D0;
        mx = 16'h0;
        for (int i = 0; i < 8; i++) begin
            tk(1);
            if (currentCommand > mx) mx = currentCommand;
        end
        chk("overshoot", 1, 32'(mx > 16'h09C3 && mx < 16'h09CB));
        tk(40);
        rd(7'h43, 0, "");
        chk("dc gain", 1, 32'(rdVal > 32'h7CD && rdVal < 32'h7D3));
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
